// [src/flash_seq_pkg.sv]
package flash_seq_pkg;

  // System clock rate and the times that the sequencer counts off.
  localparam int CLK_MHZ = 40;
  localparam int PAGE_PROG_TIME_US = 1000;
  localparam int SECTOR_ERASE_TIME_US = 100000;
  localparam int HALF_BLOCK_ERASE_TIME_US = 200000;
  localparam int BLOCK_ERASE_TIME_US = 400000;
  localparam int CHIP_ERASE_TIME_US = 20000000;
  localparam int SUSPEND_LATENCY_US = 10;
  localparam int RESUME_TIME_NS = 200;

  // Cycle counts; the resume time rounds down, and the suspend and resume counts never fall below one cycle.
  localparam longint PROG_CYC = longint'(PAGE_PROG_TIME_US) * CLK_MHZ;
  localparam longint SE_CYC = longint'(SECTOR_ERASE_TIME_US) * CLK_MHZ;
  localparam longint B32_CYC = longint'(HALF_BLOCK_ERASE_TIME_US) * CLK_MHZ;
  localparam longint B64_CYC = longint'(BLOCK_ERASE_TIME_US) * CLK_MHZ;
  localparam longint CHIP_CYC = longint'(CHIP_ERASE_TIME_US) * CLK_MHZ;
  localparam int SUSP_CYC = (SUSPEND_LATENCY_US * CLK_MHZ < 1) ? 1 : SUSPEND_LATENCY_US * CLK_MHZ;
  localparam int RESUME_CYC = (RESUME_TIME_NS * CLK_MHZ / 1000 < 1) ? 1 :
                              RESUME_TIME_NS * CLK_MHZ / 1000;

  // Opcodes.
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_QPROG = 8'h32;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_B32 = 8'h52;
  localparam logic [7:0] OP_B64 = 8'hD8;
  localparam logic [7:0] OP_CE1 = 8'hC7;
  localparam logic [7:0] OP_CE2 = 8'h60;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;

  // Frame layout on the link.
  localparam logic [5:0] OP_BITS = 6'h08;
  localparam logic [5:0] HDR_BITS = 6'h20;
  localparam logic [2:0] SINGLE_LAST = 3'h7;
  localparam logic [2:0] QUAD_LAST = 3'h1;
  localparam int PAGE_BYTES = 256;
  localparam logic [8:0] PAGE_FULL = 9'h100;

  // Region sizes, 25 bits so that a region end just past the 24-bit address range fits.
  localparam logic [24:0] LEN_PAGE = 25'h0000100;
  localparam logic [24:0] LEN_SECTOR = 25'h0001000;
  localparam logic [24:0] LEN_B32 = 25'h0008000;
  localparam logic [24:0] LEN_B64 = 25'h0010000;
  localparam logic [24:0] LEN_ARRAY = 25'h0800000;

  // Protected-range sizing from the range bits.
  localparam logic [4:0] BLK_SHIFT = 5'h10;
  localparam logic [4:0] SEC_SHIFT = 5'h0B;
  localparam logic [2:0] SEC_CAP_BP = 3'h4;

  typedef enum logic [2:0] {K_NONE, K_PROG, K_SE, K_B32, K_B64, K_CHIP} op_kind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_PAUSE, ST_RESUME} seq_state_t;

endpackage : flash_seq_pkg

// [src/flash_program_erase_suspend.sv]
`timescale 1ns/1ps
module flash_program_erase_suspend #(
  parameter longint PROG_CYC = flash_seq_pkg::PROG_CYC,
  parameter longint SE_CYC = flash_seq_pkg::SE_CYC,
  parameter longint B32_CYC = flash_seq_pkg::B32_CYC,
  parameter longint B64_CYC = flash_seq_pkg::B64_CYC,
  parameter longint CHIP_CYC = flash_seq_pkg::CHIP_CYC
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_io,
  input wire logic i_quad_enable_bit,
  input wire logic i_protect_complement_bit,
  input wire logic i_protect_sector_granularity_bit,
  input wire logic i_protect_top_bottom_bit,
  input wire logic i_protect_range_bit2,
  input wire logic i_protect_range_bit1,
  input wire logic i_protect_range_bit0,
  output logic o_busy,
  output logic o_write_enable_latch,
  output logic o_suspend_flag,
  output logic o_status_write_allow,
  output logic o_prog_wr,
  output logic [23:0] o_prog_addr,
  output logic [7:0] o_prog_data,
  output logic o_erase_req,
  output logic [23:0] o_erase_addr,
  output logic [24:0] o_erase_len
);

  localparam int SUSP_MAX = flash_seq_pkg::SUSP_CYC + 300;
  localparam int RES_MAX = flash_seq_pkg::RESUME_CYC + 1;

  // ---- Link domain, clocked by the host's serial clock. ----
  logic act_q;
  logic fr_tog_q;
  logic lock_m_q;
  logic lock_s_q;
  logic [5:0] hdr_q;
  logic [7:0] op_lk_q;
  logic [23:0] addr_lk_q;
  logic [2:0] sub_q;
  logic [6:0] sh_q;
  logic [8:0] nbytes_q;
  logic [7:0] wofs_q;
  logic [7:0] page_buf [flash_seq_pkg::PAGE_BYTES];
  logic quad_lk;
  logic byte_done;
  logic [7:0] byte_val;
  logic buf_lock_q;

  assign quad_lk = (op_lk_q == flash_seq_pkg::OP_QPROG);
  assign byte_done = (sub_q == (quad_lk ? flash_seq_pkg::QUAD_LAST : flash_seq_pkg::SINGLE_LAST));
  assign byte_val = quad_lk ? {sh_q[3:0], i_io} : {sh_q[6:0], i_io[0]};

  // The serial clock stops between frames, so chip select itself ends the frame.
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      act_q <= 1'b0;
    end else begin
      act_q <= 1'b1;
    end
  end

  // Frame marker; toggles on the first edge so the system side can tell empty frames apart.
  always_ff @(posedge i_sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fr_tog_q <= 1'b0;
    end else if (!act_q) begin
      fr_tog_q <= !fr_tog_q;
    end
  end

  // Buffer lock from the system side, two flops before use.
  always_ff @(posedge i_sclk) begin
    lock_m_q <= buf_lock_q;
    lock_s_q <= lock_m_q;
  end

  // Opcode and address on one line, then data on one or four lines.
  always_ff @(posedge i_sclk) begin
    if (!act_q) begin
      hdr_q <= 6'h01;
      op_lk_q <= {7'h00, i_io[0]};
      sub_q <= 3'h0;
      nbytes_q <= 9'h000;
      wofs_q <= 8'h00;
    end else if (hdr_q < flash_seq_pkg::HDR_BITS) begin
      hdr_q <= hdr_q + 6'h01;
      if (hdr_q < flash_seq_pkg::OP_BITS) begin
        op_lk_q <= {op_lk_q[6:0], i_io[0]};
      end else begin
        addr_lk_q <= {addr_lk_q[22:0], i_io[0]};
      end
    end else begin
      sh_q <= quad_lk ? {sh_q[2:0], i_io} : {sh_q[5:0], i_io[0]};
      sub_q <= byte_done ? 3'h0 : sub_q + 3'h1;
      if (byte_done) begin
        wofs_q <= wofs_q + 8'h01;
        if (nbytes_q != flash_seq_pkg::PAGE_FULL) begin
          nbytes_q <= nbytes_q + 9'h001;
        end
      end
    end
  end

  // Page buffer; the 8-bit index wraps to the page start and overwrites earlier bytes.
  always_ff @(posedge i_sclk) begin
    if (act_q && hdr_q == flash_seq_pkg::HDR_BITS && byte_done && !lock_s_q) begin
      page_buf[addr_lk_q[7:0] + wofs_q] <= byte_val;
    end
  end

  // ---- System domain. ----
  logic cs_m_q;
  logic cs_s_q;
  logic cs_d_q;
  logic seen_q;
  logic frame_end;
  flash_seq_pkg::seq_state_t state_q;
  flash_seq_pkg::op_kind_t kind_q;
  flash_seq_pkg::op_kind_t sv_kind_q;
  flash_seq_pkg::op_kind_t new_kind;
  logic busy_q;
  logic sus_q;
  logic wel_q;
  logic [31:0] cnt_q;
  logic [31:0] sv_cnt_q;
  logic [31:0] lat_q;
  logic [24:0] sv_base_q;
  logic [24:0] sv_len_q;
  logic [8:0] copy_left_q;
  logic [7:0] copy_ofs_q;
  logic [15:0] copy_page_q;

  // Chip select passes two flops; link values are stable once the rise is seen here.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_d_q <= 1'b1;
      seen_q <= 1'b0;
    end else begin
      cs_m_q <= i_cs_n;
      cs_s_q <= cs_m_q;
      cs_d_q <= cs_s_q;
      if (cs_s_q && !cs_d_q) begin
        seen_q <= fr_tog_q;
      end
    end
  end
  assign frame_end = cs_s_q && !cs_d_q && (fr_tog_q != seen_q);

  // Decode of the finished frame, target region and protection.
  logic len_ok;
  logic [24:0] r_len;
  logic [24:0] r_base;
  logic [24:0] r_end;
  logic [24:0] p_size;
  logic [24:0] p_lo;
  logic [24:0] p_hi;
  logic [2:0] bp;
  logic prot_hit;
  logic sv_hit;
  logic susp_block;
  logic idle_free;
  logic acc_start;
  logic acc_susp;
  logic acc_res;
  logic acc_wren;
  logic acc_wrdi;
  logic done;

  always_comb begin
    new_kind = flash_seq_pkg::K_NONE;
    len_ok = (hdr_q == flash_seq_pkg::OP_BITS);
    case (op_lk_q)
      flash_seq_pkg::OP_PROG: begin
        new_kind = flash_seq_pkg::K_PROG;
        len_ok = hdr_q == flash_seq_pkg::HDR_BITS && nbytes_q != 9'h000 && sub_q == 3'h0;
      end
      flash_seq_pkg::OP_QPROG: begin
        new_kind = i_quad_enable_bit ? flash_seq_pkg::K_PROG : flash_seq_pkg::K_NONE;
        len_ok = hdr_q == flash_seq_pkg::HDR_BITS && nbytes_q != 9'h000 && sub_q == 3'h0;
      end
      flash_seq_pkg::OP_SE: begin
        new_kind = flash_seq_pkg::K_SE;
        len_ok = hdr_q == flash_seq_pkg::HDR_BITS && nbytes_q == 9'h000 && sub_q == 3'h0;
      end
      flash_seq_pkg::OP_B32: begin
        new_kind = flash_seq_pkg::K_B32;
        len_ok = hdr_q == flash_seq_pkg::HDR_BITS && nbytes_q == 9'h000 && sub_q == 3'h0;
      end
      flash_seq_pkg::OP_B64: begin
        new_kind = flash_seq_pkg::K_B64;
        len_ok = hdr_q == flash_seq_pkg::HDR_BITS && nbytes_q == 9'h000 && sub_q == 3'h0;
      end
      flash_seq_pkg::OP_CE1, flash_seq_pkg::OP_CE2: begin
        new_kind = flash_seq_pkg::K_CHIP;
      end
      default: begin
        new_kind = flash_seq_pkg::K_NONE;
      end
    endcase
    case (new_kind)
      flash_seq_pkg::K_PROG: r_len = flash_seq_pkg::LEN_PAGE;
      flash_seq_pkg::K_SE: r_len = flash_seq_pkg::LEN_SECTOR;
      flash_seq_pkg::K_B32: r_len = flash_seq_pkg::LEN_B32;
      flash_seq_pkg::K_B64: r_len = flash_seq_pkg::LEN_B64;
      default: r_len = flash_seq_pkg::LEN_ARRAY;
    endcase
    r_base = (new_kind == flash_seq_pkg::K_CHIP) ? 25'h0000000 :
             ({1'b0, addr_lk_q} & ~(r_len - 25'h0000001));
    r_end = r_base + r_len;
  end

  // Protected window; the complement bit protects everything outside it instead.
  always_comb begin
    bp = {i_protect_range_bit2, i_protect_range_bit1, i_protect_range_bit0};
    if (bp == 3'h0) begin
      p_size = 25'h0000000;
    end else if (i_protect_sector_granularity_bit) begin
      p_size = (bp >= flash_seq_pkg::SEC_CAP_BP) ? flash_seq_pkg::LEN_B32 :
               (25'h0000001 << (flash_seq_pkg::SEC_SHIFT + {2'b00, bp}));
    end else begin
      p_size = 25'h0000001 << (flash_seq_pkg::BLK_SHIFT + {2'b00, bp});
    end
    p_lo = i_protect_top_bottom_bit ? 25'h0000000 : flash_seq_pkg::LEN_ARRAY - p_size;
    p_hi = i_protect_top_bottom_bit ? p_size : flash_seq_pkg::LEN_ARRAY;
    prot_hit = i_protect_complement_bit ? !(r_base >= p_lo && r_end <= p_hi) :
               (r_base < p_hi && r_end > p_lo);
  end

  // Acceptance of each command; anything that fails a test is dropped silently.
  always_comb begin
    sv_hit = r_base < (sv_base_q + sv_len_q) && r_end > sv_base_q;
    susp_block = sus_q && ((sv_kind_q == flash_seq_pkg::K_PROG &&
                            new_kind == flash_seq_pkg::K_PROG) ||
                           (sv_kind_q != flash_seq_pkg::K_PROG &&
                            new_kind != flash_seq_pkg::K_PROG) ||
                           sv_hit);
    idle_free = frame_end && len_ok && state_q == flash_seq_pkg::ST_IDLE && !busy_q;
    acc_wren = idle_free && op_lk_q == flash_seq_pkg::OP_WREN;
    acc_wrdi = idle_free && op_lk_q == flash_seq_pkg::OP_WRDI;
    acc_start = idle_free && new_kind != flash_seq_pkg::K_NONE && wel_q &&
                !prot_hit && !susp_block;
    acc_susp = frame_end && len_ok && op_lk_q == flash_seq_pkg::OP_SUSP && !sus_q && busy_q &&
               state_q == flash_seq_pkg::ST_RUN && kind_q != flash_seq_pkg::K_CHIP;
    acc_res = idle_free && op_lk_q == flash_seq_pkg::OP_RESUME && sus_q;
    done = state_q == flash_seq_pkg::ST_RUN && !acc_susp && cnt_q == 32'h0 &&
           copy_left_q == 9'h000;
  end

  // Cycle length per operation type.
  function automatic logic [31:0] op_cycles(input flash_seq_pkg::op_kind_t k);
    case (k)
      flash_seq_pkg::K_PROG: op_cycles = 32'(PROG_CYC - 1);
      flash_seq_pkg::K_SE: op_cycles = 32'(SE_CYC - 1);
      flash_seq_pkg::K_B32: op_cycles = 32'(B32_CYC - 1);
      flash_seq_pkg::K_B64: op_cycles = 32'(B64_CYC - 1);
      default: op_cycles = 32'(CHIP_CYC - 1);
    endcase
  endfunction : op_cycles

  // Sequencer: runs, pauses on suspend, parks the paused context, and restores it on resume.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= flash_seq_pkg::ST_IDLE;
      kind_q <= flash_seq_pkg::K_NONE;
      sv_kind_q <= flash_seq_pkg::K_NONE;
      busy_q <= 1'b0;
      sus_q <= 1'b0;
      cnt_q <= 32'h0;
      sv_cnt_q <= 32'h0;
      lat_q <= 32'h0;
      sv_base_q <= 25'h0000000;
      sv_len_q <= 25'h0000000;
    end else begin
      case (state_q)
        flash_seq_pkg::ST_IDLE: begin
          if (acc_start) begin
            state_q <= flash_seq_pkg::ST_RUN;
            busy_q <= 1'b1;
            kind_q <= new_kind;
            cnt_q <= op_cycles(new_kind);
          end else if (acc_res) begin
            sus_q <= 1'b0;
            lat_q <= 32'(flash_seq_pkg::RESUME_CYC - 1);
            state_q <= flash_seq_pkg::ST_RESUME;
          end
        end
        flash_seq_pkg::ST_RUN: begin
          if (acc_susp) begin
            sus_q <= 1'b1;
            lat_q <= 32'(flash_seq_pkg::SUSP_CYC - 1);
            state_q <= flash_seq_pkg::ST_PAUSE;
          end else if (done) begin
            busy_q <= 1'b0;
            kind_q <= flash_seq_pkg::K_NONE;
            state_q <= flash_seq_pkg::ST_IDLE;
          end else if (cnt_q != 32'h0) begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        flash_seq_pkg::ST_PAUSE: begin
          if (lat_q != 32'h0) begin
            lat_q <= lat_q - 32'h1;
          end else if (copy_left_q == 9'h000) begin
            busy_q <= 1'b0;
            sv_kind_q <= kind_q;
            sv_cnt_q <= cnt_q;
            kind_q <= flash_seq_pkg::K_NONE;
            state_q <= flash_seq_pkg::ST_IDLE;
          end
        end
        flash_seq_pkg::ST_RESUME: begin
          if (lat_q != 32'h0) begin
            lat_q <= lat_q - 32'h1;
          end else begin
            busy_q <= 1'b1;
            kind_q <= sv_kind_q;
            cnt_q <= sv_cnt_q;
            sv_kind_q <= flash_seq_pkg::K_NONE;
            state_q <= flash_seq_pkg::ST_RUN;
          end
        end
        default: begin
          state_q <= flash_seq_pkg::ST_IDLE;
        end
      endcase
      if (acc_start) begin
        sv_base_q <= sus_q ? sv_base_q : r_base;
        sv_len_q <= sus_q ? sv_len_q : r_len;
      end
    end
  end

  // Write enable latch; set and clear never coincide: WRDI is another opcode, and completion needs the run state.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wel_q <= 1'b0;
    end else if (acc_wren) begin
      wel_q <= 1'b1;
    end else if (acc_wrdi || done) begin
      wel_q <= 1'b0;
    end
  end

  // Byte copy from the page buffer to the array port, one byte per cycle, wrapping in the page.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      copy_left_q <= 9'h000;
      copy_ofs_q <= 8'h00;
      copy_page_q <= 16'h0000;
      buf_lock_q <= 1'b0;
      o_prog_wr <= 1'b0;
      o_prog_addr <= 24'h000000;
      o_prog_data <= 8'h00;
    end else if (acc_start && new_kind == flash_seq_pkg::K_PROG) begin
      copy_left_q <= nbytes_q;
      copy_ofs_q <= addr_lk_q[7:0];
      copy_page_q <= addr_lk_q[23:8];
      buf_lock_q <= 1'b1;
      o_prog_wr <= 1'b0;
    end else if (copy_left_q != 9'h000) begin
      o_prog_wr <= 1'b1;
      o_prog_addr <= {copy_page_q, copy_ofs_q};
      o_prog_data <= page_buf[copy_ofs_q];
      copy_ofs_q <= copy_ofs_q + 8'h01;
      copy_left_q <= copy_left_q - 9'h001;
    end else begin
      o_prog_wr <= 1'b0;
      buf_lock_q <= 1'b0;
    end
  end

  // Erase request to the array, one pulse when an erase starts.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_erase_req <= 1'b0;
      o_erase_addr <= 24'h000000;
      o_erase_len <= 25'h0000000;
    end else begin
      o_erase_req <= acc_start && new_kind != flash_seq_pkg::K_PROG;
      if (acc_start) begin
        o_erase_addr <= r_base[23:0];
        o_erase_len <= r_len;
      end
    end
  end

  // Status writes are allowed while the suspend flag is clear, one cycle later.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_status_write_allow <= 1'b1;
    end else begin
      o_status_write_allow <= !sus_q;
    end
  end

  assign o_busy = busy_q;
  assign o_write_enable_latch = wel_q;
  assign o_suspend_flag = sus_q;

  // Checks, all on the system clock.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  quad_gate_a: assert property (frame_end && op_lk_q == flash_seq_pkg::OP_QPROG &&
    (!i_quad_enable_bit || !wel_q) && state_q == flash_seq_pkg::ST_IDLE && !busy_q
    |=> !o_busy) else $error("quad program taken without enable");
  erase_wel_a: assert property (frame_end && !wel_q && !busy_q &&
    state_q == flash_seq_pkg::ST_IDLE |=> !o_busy && !o_erase_req)
    else $error("erase taken without write latch");
  bad_len_a: assert property (frame_end && !len_ok && !busy_q |=> (!o_busy) [*2])
    else $error("misaligned frame executed");
  busy_hold_a: assert property (acc_start |=> o_busy throughout (!done [*3]))
    else $error("busy not held after start");
  wel_clear_a: assert property (done |=> !o_write_enable_latch && !o_busy)
    else $error("latch not cleared on completion");
  prot_refuse_a: assert property (frame_end && prot_hit && !busy_q |=> !o_busy)
    else $error("protected region started");
  chip_susp_a: assert property (frame_end && kind_q == flash_seq_pkg::K_CHIP &&
    !sus_q |=> !o_suspend_flag) else $error("chip erase suspended");
  susp_lat_a: assert property (acc_susp |=> o_suspend_flag ##[1:SUSP_MAX] !o_busy)
    else $error("busy not released within suspend latency");
  resume_busy_a: assert property (acc_res |=> !o_suspend_flag ##[0:RES_MAX] o_busy)
    else $error("busy not restored after resume");
  busy_ignore_a: assert property (frame_end && busy_q |=> $stable(o_write_enable_latch))
    else $error("command acted on while busy");
  pwr_loss_a: assert property (@(posedge i_clk) disable iff (1'b0) i_sys_rst |=>
    !o_suspend_flag) else $error("suspend flag survives reset");

  prog_done_c: cover property (done && kind_q == flash_seq_pkg::K_PROG);
  susp_res_c: cover property (acc_res && sv_kind_q != flash_seq_pkg::K_NONE);
  chip_c: cover property (acc_start && new_kind == flash_seq_pkg::K_CHIP);

endmodule : flash_program_erase_suspend

// [dv/flash_host_model.sv]
`timescale 1ns/1ps
// Host end of the serial link. The link clock stands still outside frames.
module flash_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_io
);
  // A short low pulse at start gives the frame-active flop a real clearing edge.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b0;
    o_io = 4'h0;
    #1 o_cs_n = 1'b1;
  end
  // One unit per clock: lines change on the low phase, the device samples on the rise.
  task automatic put(input logic [3:0] v);
    o_io = v;
    #32 o_sclk = 1'b1;
    #32 o_sclk = 1'b0;
  endtask : put
  // Opcode, optional address, n data bytes; t drops trailing header clocks to misalign.
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input bit ha, input int n,
                       input bit q, input int t);
    logic [31:0] sh;
    logic [7:0] d;
    sh = {op, a};
    o_cs_n = 1'b0;
    #32;
    for (int i = 0; i < (ha ? 32 : 8) - t; i++) put({3'h0, sh[31 - i]});
    for (int k = 0; k < n; k++) begin
      d = 8'hA0 + k[7:0];
      for (int j = 0; j < (q ? 2 : 8); j++) begin
        put(q ? (j == 0 ? d[7:4] : d[3:0]) : {3'h0, d[7 - j]});
      end
    end
    // Released lines show the inverse so a stale value is never mistaken for data.
    #32 o_cs_n = 1'b1;
    o_io = ~o_io;
    #200;
  endtask : frame
endmodule : flash_host_model

// [dv/test_flash_program_erase_suspend.sv]
`timescale 1ns/1ps
module test_flash_program_erase_suspend;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic qe = 1'b0;
  logic [5:0] prot = 6'h00;
  logic sclk, cs_n, busy, write_enable_latch, suspend_flag, swa, pwr, ereq;
  logic [3:0] io;
  logic [23:0] paddr, eaddr;
  logic [7:0] pdata;
  logic [24:0] elen;
  int n_errors = 0;
  int checked = 0;
  int n_er = 0;
  int w, m;
  logic [31:0] pq [$];
  logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
  logic [24:0] ln [5] = '{25'h0001000, 25'h0008000, 25'h0010000, 25'h0800000, 25'h0800000};
  int cy [5] = '{120, 160, 200, 240, 240};
  // The 40 MHz system clock.
  always #12.5 clk = ~clk;
  flash_host_model i_flash_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(io));
  flash_program_erase_suspend #(.PROG_CYC(80), .SE_CYC(120), .B32_CYC(160), .B64_CYC(200),
    .CHIP_CYC(240)) i_flash_program_erase_suspend (
    .i_clk(clk), .i_sys_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_io(io),
    .i_quad_enable_bit(qe), .i_protect_complement_bit(prot[5]),
    .i_protect_sector_granularity_bit(prot[4]), .i_protect_top_bottom_bit(prot[3]),
    .i_protect_range_bit2(prot[2]), .i_protect_range_bit1(prot[1]),
    .i_protect_range_bit0(prot[0]), .o_busy(busy), .o_write_enable_latch(write_enable_latch),
    .o_suspend_flag(suspend_flag), .o_status_write_allow(swa), .o_prog_wr(pwr), .o_prog_addr(paddr),
    .o_prog_data(pdata), .o_erase_req(ereq), .o_erase_addr(eaddr), .o_erase_len(elen));
  // Pulses are one cycle wide, so they are recorded as they happen.
  always @(posedge clk) begin
    if (ereq === 1'b1) n_er++;
    if (pwr === 1'b1) pq.push_back({paddr, pdata});
  end
  task automatic cmpb(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t flag is %b, expected %b", $time, g, e);
    end
  endtask : cmpb
  task automatic cmpv(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t value is %h, expected %h", $time, g, e);
    end
  endtask : cmpv
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // The host keeps the line idle long enough for the decode to land before returning.
  task automatic fr(input logic [7:0] op, input logic [23:0] a, input bit ha, input int n,
                    input bit q, input int t);
    i_flash_host_model.frame(op, a, ha, n, q, t);
    cyc(2);
  endtask : fr
  task automatic wren();
    fr(flash_seq_pkg::OP_WREN, 24'h0, 0, 0, 0, 0);
  endtask : wren
  // Bounded wait for the end of a cycle; w returns the cycles waited.
  task automatic idle(output int w);
    for (w = 0; w < 3000 && busy !== 1'b0; w++) cyc(1);
  endtask : idle
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    #2000000;
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    conclude();
  end
  // Reset rises after time zero so the link-side toggle sees a real edge.
  initial begin
    #1 rst = 1'b1;
    cyc(8);
    rst = 1'b0;
    cyc(4);
    cmpb(swa, 1'b1);
    fr(flash_seq_pkg::OP_SE, 24'h001000, 1, 0, 0, 0);
    cmpb(busy, 1'b0);
    for (int k = 0; k < 5; k++) begin
      wren();
      m = n_er;
      fr(ops[k], 24'h123456, k < 3, 0, 0, 0);
      cmpb(busy, 1'b1);
      cmpv(32'(n_er - m), 32'h1);
      cmpv(eaddr, 24'h123456 & ~(ln[k][23:0] - 24'h1));
      cmpv(elen, ln[k]);
      idle(w);
      cmpb(w >= cy[k] - 15 && w <= cy[k], 1'b1);
      cmpb(write_enable_latch, 1'b0);
    end
    // A header one clock short must be thrown away.
    wren();
    fr(flash_seq_pkg::OP_SE, 24'h001000, 1, 0, 0, 1);
    cmpb(busy, 1'b0);
    fr(flash_seq_pkg::OP_QPROG, 24'h0000FE, 1, 3, 1, 0);
    cmpb(busy, 1'b0);
    qe = 1'b1;
    fr(flash_seq_pkg::OP_QPROG, 24'h0000FE, 1, 3, 1, 0);
    idle(w);
    for (int k = 0; k < 3; k++) begin
      cmpv(pq.pop_front(), {16'h0, 8'hFE + k[7:0], 8'hA0 + k[7:0]});
    end
    // Suspend an erase, try work inside and outside the rules, then resume.
    // The 64K erase is used since it outlasts the two frames sent before the suspend.
    wren();
    fr(flash_seq_pkg::OP_B64, 24'h010000, 1, 0, 0, 0);
    m = n_er;
    fr(flash_seq_pkg::OP_B64, 24'h200000, 1, 0, 0, 0);
    cmpv(32'(n_er - m), 32'h0);
    fr(flash_seq_pkg::OP_SUSP, 24'h0, 0, 0, 0, 0);
    cmpb(suspend_flag, 1'b1);
    cmpb(busy, 1'b1);
    idle(w);
    cmpb(w > 380 && w <= 400, 1'b1);
    cmpb(swa, 1'b0);
    wren();
    fr(flash_seq_pkg::OP_B64, 24'h200000, 1, 0, 0, 0);
    cmpb(busy, 1'b0);
    fr(flash_seq_pkg::OP_PROG, 24'h300010, 1, 1, 0, 0);
    idle(w);
    cmpv(pq.pop_front(), {24'h300010, 8'hA0});
    fr(flash_seq_pkg::OP_RESUME, 24'h0, 0, 0, 0, 0);
    cmpb(suspend_flag, 1'b0);
    cyc(4);
    cmpb(busy, 1'b1);
    cyc(400);
    idle(w);
    fr(flash_seq_pkg::OP_SUSP, 24'h0, 0, 0, 0, 0);
    cmpb(suspend_flag, 1'b0);
    wren();
    fr(flash_seq_pkg::OP_CE1, 24'h0, 0, 0, 0, 0);
    fr(flash_seq_pkg::OP_SUSP, 24'h0, 0, 0, 0, 0);
    cmpb(suspend_flag, 1'b0);
    idle(w);
    // Top 128K protected: the sector there and the whole array are refused.
    prot = 6'h01;
    wren();
    fr(flash_seq_pkg::OP_SE, 24'h7F0000, 1, 0, 0, 0);
    cmpb(busy, 1'b0);
    fr(flash_seq_pkg::OP_CE2, 24'h0, 0, 0, 0, 0);
    cmpb(busy, 1'b0);
    prot = 6'h00;
    fr(flash_seq_pkg::OP_SE, 24'h020000, 1, 0, 0, 0);
    fr(flash_seq_pkg::OP_SUSP, 24'h0, 0, 0, 0, 0);
    cmpb(suspend_flag, 1'b1);
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    cmpb(suspend_flag, 1'b0);
    cmpb(busy, 1'b0);
    conclude();
  end
endmodule : test_flash_program_erase_suspend
